// file: logic/sam_pkg.sv
// Package of constants and types for the security attribution map.
package sam_pkg;
  // Register offsets, byte addresses on the register port.
  localparam logic [31:0] ATTRIBUTION_CONTROL_OFS = 32'he000edd0;
  localparam logic [31:0] ATTRIBUTION_TYPE_INFO_OFS = 32'he000edd4;
  localparam logic [31:0] REGION_INDEX_SELECT_OFS = 32'he000edd8;
  localparam logic [31:0] REGION_BASE_ADDRESS_OFS = 32'he000eddc;
  localparam logic [31:0] REGION_LIMIT_ADDRESS_OFS = 32'he000ede0;
  // Field positions.
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_ALL_NONSECURE_DEFAULT_BIT = 1;
  localparam int LIMIT_ENABLE_BIT = 0;
  localparam int LIMIT_CALLABLE_BIT = 1;
  localparam int ADDR_LOW_BITS = 5;
  // Reset values.
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [7:0] INDEX_RESET = 8'h00;
  localparam logic [26:0] BITS_RESET = 27'h0000000;
  // Attribute encoding, ordered from least to most secure.
  typedef enum logic [1:0]
  {
    ATTR_NONSECURE = 2'h0,
    ATTR_CALLABLE = 2'h1,
    ATTR_SECURE = 2'h2
  } sam_attr_t;
  // More secure of two attributes.
  function automatic sam_attr_t sam_stronger(input sam_attr_t a,
                                             input sam_attr_t b);
    sam_stronger = (a > b) ? a : b;
  endfunction : sam_stronger
endpackage : sam_pkg

// file: logic/sam_cfg_if.sv
// Interface carrying region configuration from the register bank.
`timescale 1ns/100ps
`default_nettype none
interface sam_cfg_if;
  logic [7:0] regionEnable;
  logic [7:0] regionCallable;
  logic [26:0] baseBits [8];
  logic [26:0] limitBits [8];
  logic unitEnable;
  logic allNonsecure;
  modport bank (output regionEnable, regionCallable, baseBits, limitBits,
                unitEnable, allNonsecure);
  modport lookup (input regionEnable, regionCallable, baseBits, limitBits,
                  unitEnable, allNonsecure);
endinterface : sam_cfg_if
`default_nettype wire

// file: logic/sam_lookup.sv
// Combinational attribution lookup for one address.
`timescale 1ns/100ps
`default_nettype none
module sam_lookup
  import sam_pkg::*;
#(
  parameter int RegionCount = 8
)
(
  // Configuration.
  sam_cfg_if.lookup cfg,
  // Query.
  input wire logic [31:0] addr,
  input wire logic extPresent,
  input wire sam_attr_t extAttr,
  // Result.
  output sam_attr_t attr,
  output logic [7:0] regionNum,
  output logic regionValid
);
  logic [7:0] hit;
  logic [3:0] hitCount;
  sam_attr_t regAttr;

  // Region match; limit low bits implied as ones.
  always_comb
  begin
    hit = 8'h00;
    hitCount = 4'h0;
    regionNum = 8'h00;
    for (int i = 0; i < RegionCount; i++)
    begin
      if (cfg.regionEnable[i] && addr[31:5] >= cfg.baseBits[i] &&
          addr[31:5] <= cfg.limitBits[i])
      begin
        hit[i] = 1'b1;
        hitCount = hitCount + 4'h1;
        regionNum = 8'(i);
      end
    end
  end

  // Programmable attribute, then merge with the fixed external map.
  always_comb
  begin
    if (!cfg.unitEnable)
      regAttr = cfg.allNonsecure ? ATTR_NONSECURE : ATTR_SECURE;
    else if (hitCount == 4'h0 || hitCount > 4'h1)
      regAttr = ATTR_SECURE;
    else if ((hit & cfg.regionCallable) != 8'h00)
      regAttr = ATTR_CALLABLE;
    else
      regAttr = ATTR_NONSECURE;
    // Regions override the external map only toward more security.
    attr = extPresent ? sam_stronger(regAttr, extAttr) : regAttr;
    regionValid = cfg.unitEnable && hitCount == 4'h1;
  end
endmodule : sam_lookup
`default_nettype wire

// file: logic/sam_regbank.sv
// Register bank of the attribution unit, Secure-only access.
`timescale 1ns/100ps
`default_nettype none
module sam_regbank
  import sam_pkg::*;
#(
  parameter int RegionCount = 8
)
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Register port.
  input wire logic [31:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic regSecure,
  output logic [31:0] regRdata_q,
  // Configuration out.
  sam_cfg_if.bank cfg
);
  logic [1:0] ctrl_q;
  logic [7:0] index_q;
  logic [26:0] base_q [8];
  logic [26:0] limit_q [8];
  logic [7:0] en_q;
  logic [7:0] nsc_q;
  logic secWrite;
  logic idxOk;
  logic [31:0] regRdata_d;

  assign secWrite = regWrite && regSecure;
  assign idxOk = index_q < 8'(RegionCount);

  // Control register, cleared at reset.
  always_ff @(posedge clock)
  begin
    if (rst)
      ctrl_q <= CTRL_RESET;
    else if (secWrite && regAddr == ATTRIBUTION_CONTROL_OFS)
      ctrl_q <= regWdata[1:0];
  end

  // Region index select.
  always_ff @(posedge clock)
  begin
    if (rst)
      index_q <= INDEX_RESET;
    else if (secWrite && regAddr == REGION_INDEX_SELECT_OFS)
      index_q <= regWdata[7:0];
  end

  // Region storage reached through the index.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      en_q <= 8'h00;
      nsc_q <= 8'h00;
      for (int i = 0; i < 8; i++)
      begin
        base_q[i] <= BITS_RESET;
        limit_q[i] <= BITS_RESET;
      end
    end
    else if (secWrite && idxOk)
    begin
      if (regAddr == REGION_BASE_ADDRESS_OFS)
        base_q[index_q[2:0]] <= regWdata[31:5];
      if (regAddr == REGION_LIMIT_ADDRESS_OFS)
      begin
        limit_q[index_q[2:0]] <= regWdata[31:5];
        en_q[index_q[2:0]] <= regWdata[LIMIT_ENABLE_BIT];
        nsc_q[index_q[2:0]] <= regWdata[LIMIT_CALLABLE_BIT];
      end
    end
  end

  // Read mux; Non-secure reads return zero.
  always_comb
  begin
    regRdata_d = 32'h00000000;
    if (regRead && regSecure)
    begin
      case (regAddr)
        ATTRIBUTION_CONTROL_OFS: regRdata_d = {30'h0, ctrl_q};
        ATTRIBUTION_TYPE_INFO_OFS:
          regRdata_d = {24'h0, 8'(RegionCount)};
        REGION_INDEX_SELECT_OFS: regRdata_d = {24'h0, index_q};
        REGION_BASE_ADDRESS_OFS:
          if (idxOk)
            regRdata_d = {base_q[index_q[2:0]], 5'h00};
        REGION_LIMIT_ADDRESS_OFS:
          if (idxOk)
            regRdata_d = {limit_q[index_q[2:0]], 3'h0,
                          nsc_q[index_q[2:0]], en_q[index_q[2:0]]};
        default: regRdata_d = 32'h00000000;
      endcase
    end
  end

  // Read data stands in the cycle after the strobe.
  always_ff @(posedge clock)
  begin
    if (rst)
      regRdata_q <= 32'h00000000;
    else
      regRdata_q <= regRdata_d;
  end

  // Drive configuration, masking unimplemented regions.
  always_comb
  begin
    cfg.unitEnable = ctrl_q[CTRL_ENABLE_BIT];
    cfg.allNonsecure = ctrl_q[CTRL_ALL_NONSECURE_DEFAULT_BIT];
    cfg.regionEnable = en_q & 8'((9'h1 << RegionCount) - 9'h1);
    cfg.regionCallable = nsc_q;
    cfg.baseBits = base_q;
    cfg.limitBits = limit_q;
  end

  // Reset clears the control register on the following edge.
  a_ctrl_reset: assert property (@(posedge clock)
    rst |=> ctrl_q == CTRL_RESET)
    else $error("control not cleared by reset");
  a_ns_write: assert property (@(posedge clock) disable iff (rst)
    regWrite && !regSecure |=> $stable(ctrl_q) && $stable(index_q))
    else $error("nonsecure write changed a register");
  a_ns_read: assert property (@(posedge clock) disable iff (rst)
    regRead && !regSecure |=> regRdata_q == 32'h0)
    else $error("nonsecure read not zero");
  a_type: assert property (@(posedge clock) disable iff (rst)
    regRead && regSecure && regAddr == ATTRIBUTION_TYPE_INFO_OFS
    |=> regRdata_q == 32'(RegionCount))
    else $error("type register wrong");
endmodule : sam_regbank
`default_nettype wire

// file: logic/security_attribution_map.sv
// Top of the security attribution map beside the core.
`timescale 1ns/100ps
`default_nettype none
module security_attribution_map
  import sam_pkg::*;
#(
  parameter int RegionCount = 8
)
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Register port.
  input wire logic [31:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic regSecure,
  output logic [31:0] regRdata_q,
  // External fixed attribution.
  input wire logic extPresent,
  input wire logic [1:0] fetchExtAttr,
  input wire logic [1:0] dataExtAttr,
  // Instruction fetch query.
  input wire logic fetchValid,
  input wire logic [31:0] fetchAddr,
  input wire logic fetchIsGateway,
  input wire logic coreSecure,
  output logic [1:0] fetchAttr_q,
  output logic fetchCallable_q,
  output logic gatewayTaken_q,
  output logic fetchFault_q,
  // Data access query.
  input wire logic dataValid,
  input wire logic [31:0] dataAddr,
  output logic [1:0] dataAttr_q,
  output logic dataGrant_q,
  output logic busNonsecure_q,
  output logic securityFault_q,
  // Target test result for the data address.
  output logic [7:0] testRegion_q,
  output logic testRegionValid_q,
  // Request to switch to Non-secure state.
  input wire logic enterNsReq,
  output logic enterNsFault_q
);
  sam_cfg_if cfg ();
  sam_attr_t fAttr;
  sam_attr_t dAttr;
  logic [7:0] dRegion;
  logic dRegionOk;
  logic noNsAnywhere;

  // Register bank.
  sam_regbank #(.RegionCount(RegionCount)) u_bank
  (
    .clock(clock),
    .rst(rst),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWrite(regWrite),
    .regRead(regRead),
    .regSecure(regSecure),
    .regRdata_q(regRdata_q),
    .cfg(cfg)
  );

  // Fetch lookup.
  sam_lookup #(.RegionCount(RegionCount)) u_fetch
  (
    .cfg(cfg),
    .addr(fetchAddr),
    .extPresent(extPresent),
    .extAttr(sam_attr_t'(fetchExtAttr)),
    .attr(fAttr),
    .regionNum(),
    .regionValid()
  );

  // Data lookup.
  sam_lookup #(.RegionCount(RegionCount)) u_data
  (
    .cfg(cfg),
    .addr(dataAddr),
    .extPresent(extPresent),
    .extAttr(sam_attr_t'(dataExtAttr)),
    .attr(dAttr),
    .regionNum(dRegion),
    .regionValid(dRegionOk)
  );

  // No Non-secure memory can exist: no external map, and unit off without all-NS or on with no regions.
  assign noNsAnywhere = !extPresent && ((!cfg.unitEnable &&
    !cfg.allNonsecure) || (cfg.unitEnable && RegionCount == 0));

  // Fetch results.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      fetchAttr_q <= ATTR_SECURE;
      fetchCallable_q <= 1'b0;
      gatewayTaken_q <= 1'b0;
      fetchFault_q <= 1'b0;
    end
    else
    begin
      fetchAttr_q <= fAttr;
      fetchCallable_q <= fetchValid && fAttr == ATTR_CALLABLE;
      // Gateway only opens from callable memory while Non-secure.
      gatewayTaken_q <= fetchValid && fetchIsGateway && !coreSecure &&
                        fAttr == ATTR_CALLABLE;
      // Non-secure fetch from Secure code without valid gateway faults.
      fetchFault_q <= fetchValid && !coreSecure && fAttr != ATTR_NONSECURE &&
                      !(fetchIsGateway && fAttr == ATTR_CALLABLE);
    end
  end

  // Data results.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      dataAttr_q <= ATTR_SECURE;
      dataGrant_q <= 1'b0;
      busNonsecure_q <= 1'b0;
      securityFault_q <= 1'b0;
    end
    else
    begin
      dataAttr_q <= dAttr;
      dataGrant_q <= dataValid &&
                     (coreSecure || dAttr == ATTR_NONSECURE);
      securityFault_q <= dataValid && !coreSecure &&
                         dAttr != ATTR_NONSECURE;
      // Non-secure cores and Non-secure addresses both go out as NS.
      busNonsecure_q <= dataValid &&
        (!coreSecure || dAttr == ATTR_NONSECURE);
    end
  end

  // Target test information.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      testRegion_q <= 8'h00;
      testRegionValid_q <= 1'b0;
    end
    else
    begin
      testRegion_q <= dRegionOk ? dRegion : 8'h00;
      testRegionValid_q <= dRegionOk;
    end
  end

  // State switch guard.
  always_ff @(posedge clock)
  begin
    if (rst)
      enterNsFault_q <= 1'b0;
    else
      enterNsFault_q <= enterNsReq && noNsAnywhere;
  end

  // Non-secure data access to Secure memory is blocked and faulted.
  a_sfault: assert property (@(posedge clock) disable iff (rst)
    dataValid && !coreSecure && dAttr == ATTR_SECURE
    |=> securityFault_q && !dataGrant_q)
    else $error("nonsecure access to secure not faulted");
  // Non-secure data access to Non-secure memory goes through.
  a_ns_grant: assert property (@(posedge clock) disable iff (rst)
    dataValid && !coreSecure && dAttr == ATTR_NONSECURE
    |=> dataGrant_q && !securityFault_q)
    else $error("nonsecure access to nonsecure memory refused");
  a_busns: assert property (@(posedge clock) disable iff (rst)
    dataValid && coreSecure && dAttr == ATTR_NONSECURE
    |=> busNonsecure_q && dataGrant_q)
    else $error("secure access to ns address not marked ns");
  a_gateway: assert property (@(posedge clock) disable iff (rst)
    gatewayTaken_q |-> $past(fAttr) == ATTR_CALLABLE)
    else $error("gateway taken outside callable memory");
  // A Non-secure fetch from plain Secure memory never opens the gateway.
  a_ns_fetch: assert property (@(posedge clock) disable iff (rst)
    fetchValid && !coreSecure && fAttr == ATTR_SECURE
    |=> fetchFault_q && !gatewayTaken_q)
    else $error("nonsecure fetch from secure memory not faulted");
  a_default_sec: assert property (@(posedge clock) disable iff (rst)
    !extPresent && !cfg.unitEnable && !cfg.allNonsecure
    |-> dAttr == ATTR_SECURE && fAttr == ATTR_SECURE)
    else $error("disabled unit not all secure");
  a_all_nonsecure_default: assert property (@(posedge clock) disable iff (rst)
    !extPresent && !cfg.unitEnable && cfg.allNonsecure
    |-> dAttr == ATTR_NONSECURE)
    else $error("all nonsecure default ignored");
  a_stronger: assert property (@(posedge clock) disable iff (rst)
    extPresent && dataExtAttr == 2'h2 |-> dAttr == ATTR_SECURE)
    else $error("weaker attribute won over external map");
  a_enterns: assert property (@(posedge clock) disable iff (rst)
    enterNsReq && noNsAnywhere |=> enterNsFault_q)
    else $error("state switch not faulted");
  // A disabled unit never reports a valid region number.
  a_no_region: assert property (@(posedge clock) disable iff (rst)
    !cfg.unitEnable |=> !testRegionValid_q)
    else $error("region number valid while unit disabled");
endmodule : security_attribution_map
`default_nettype wire

// file: tb/sam_core_model.sv
// Core-side model that issues fetch, data and state-switch queries.
`timescale 1ns/100ps
`default_nettype none
module sam_core_model
(
  // Clock.
  input wire logic clock,
  // Queries toward the attribution map.
  output logic fetchValid,
  output logic [31:0] fetchAddr,
  output logic fetchIsGateway,
  output logic coreSecure,
  output logic dataValid,
  output logic [31:0] dataAddr,
  output logic enterNsReq
);
  // Idle values at time zero; the core starts in Secure state.
  initial
  begin
    fetchValid = 1'b0;
    fetchAddr = 32'h0;
    fetchIsGateway = 1'b0;
    coreSecure = 1'b1;
    dataValid = 1'b0;
    dataAddr = 32'h0;
    enterNsReq = 1'b0;
  end

  // One data access; the stale address is inverted so it cannot match.
  task automatic data(input logic [31:0] a, input logic s);
    @(posedge clock);
    dataValid <= 1'b1;
    dataAddr <= a;
    coreSecure <= s;
    @(posedge clock);
    dataValid <= 1'b0;
    dataAddr <= ~a;
  endtask : data

  // One fetch from Non-secure state, normally a call through a gateway.
  task automatic fetch(input logic [31:0] a, input logic gw);
    @(posedge clock);
    fetchValid <= 1'b1;
    fetchAddr <= a;
    fetchIsGateway <= gw;
    coreSecure <= 1'b0;
    @(posedge clock);
    fetchValid <= 1'b0;
    fetchAddr <= ~a;
    fetchIsGateway <= ~gw;
  endtask : fetch

  // One request to switch to Non-secure state.
  task automatic enterNs;
    @(posedge clock);
    enterNsReq <= 1'b1;
    @(posedge clock);
    enterNsReq <= 1'b0;
  endtask : enterNs
endmodule : sam_core_model
`default_nettype wire

// file: tb/security_attribution_map_tb.sv
// Self-checking bench for the security attribution map.
`timescale 1ns/100ps
`default_nettype none
module security_attribution_map_tb
  import sam_pkg::*;
;
  localparam int NREG = 8;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [31:0] regAddr = 32'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic regSecure = 1'b1;
  logic [31:0] regRdata_q;
  logic extPresent = 1'b0;
  logic [1:0] extAttr = 2'h0;
  logic fetchValid, fetchIsGateway, coreSecure, dataValid, enterNsReq;
  logic [31:0] fetchAddr, dataAddr;
  logic [1:0] fetchAttr_q, dataAttr_q;
  logic fetchCallable_q, gatewayTaken_q, fetchFault_q, dataGrant_q;
  logic busNonsecure_q, securityFault_q, testRegionValid_q;
  logic enterNsFault_q;
  logic [7:0] testRegion_q;
  int fails = 0;
  int nChecks = 0;
  int cyc = 0;

  // Clock of 20 ns period.
  always #10 clock = ~clock;

  security_attribution_map #(.RegionCount(NREG)) u_dut (
    .clock(clock), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regSecure(regSecure),
    .regRdata_q(regRdata_q), .extPresent(extPresent),
    .fetchExtAttr(extAttr), .dataExtAttr(extAttr),
    .fetchValid(fetchValid), .fetchAddr(fetchAddr),
    .fetchIsGateway(fetchIsGateway), .coreSecure(coreSecure),
    .fetchAttr_q(fetchAttr_q), .fetchCallable_q(fetchCallable_q),
    .gatewayTaken_q(gatewayTaken_q), .fetchFault_q(fetchFault_q),
    .dataValid(dataValid), .dataAddr(dataAddr), .dataAttr_q(dataAttr_q),
    .dataGrant_q(dataGrant_q), .busNonsecure_q(busNonsecure_q),
    .securityFault_q(securityFault_q), .testRegion_q(testRegion_q),
    .testRegionValid_q(testRegionValid_q), .enterNsReq(enterNsReq),
    .enterNsFault_q(enterNsFault_q));

  sam_core_model u_core (
    .clock(clock), .fetchValid(fetchValid), .fetchAddr(fetchAddr),
    .fetchIsGateway(fetchIsGateway), .coreSecure(coreSecure),
    .dataValid(dataValid), .dataAddr(dataAddr), .enterNsReq(enterNsReq));

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize;
    $display("checks %0d mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // Compares one observed value with its expectation.
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    nChecks++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Register write, one strobe cycle.
  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic s);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    regSecure <= s;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : wr

  // Register read; data are checked in the cycle after the strobe.
  task automatic rd(input logic [31:0] a, input logic [31:0] e,
                    input logic s);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    regSecure <= s;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    chk("regRdata", e, regRdata_q);
  endtask : rd

  // Data query with expected attribute and fault.
  task automatic dchk(input logic [31:0] a, input logic s,
                      input logic [1:0] at, input logic f);
    u_core.data(a, s);
    #1;
    chk("dataAttr", at, dataAttr_q);
    chk("securityFault", f, securityFault_q);
    chk("dataGrant", !f, dataGrant_q);
    if (!f)
      chk("busNonsecure", at == 2'h0, busNonsecure_q);
  endtask : dchk

  // Non-secure fetch with expected gateway, callable and fault flags.
  task automatic fchk(input logic [31:0] a, input logic gw,
                      input logic [1:0] at, input logic t, input logic c,
                      input logic f);
    u_core.fetch(a, gw);
    #1;
    chk("fetchAttr", at, fetchAttr_q);
    chk("gatewayTaken", t, gatewayTaken_q);
    chk("fetchCallable", c, fetchCallable_q);
    chk("fetchFault", f, fetchFault_q);
  endtask : fchk

  // State-switch request with expected fault.
  task automatic echk(input logic f);
    u_core.enterNs();
    #1;
    chk("enterNsFault", f, enterNsFault_q);
  endtask : echk

  // Cuts a hang short.
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      summarize();
    end
  end

  // Main sequence.
  initial
  begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    rd(ATTRIBUTION_CONTROL_OFS, 32'h0, 1'b1);
    rd(ATTRIBUTION_TYPE_INFO_OFS, NREG, 1'b1);
    dchk(32'h20200010, 1'b0, 2'h2, 1'b1);
    echk(1'b1);
    wr(ATTRIBUTION_CONTROL_OFS, 32'hffffffff, 1'b0);
    rd(ATTRIBUTION_CONTROL_OFS, 32'h0, 1'b1);
    wr(ATTRIBUTION_CONTROL_OFS, 32'hfffffffe, 1'b1);
    rd(ATTRIBUTION_CONTROL_OFS, 32'h2, 1'b1);
    rd(ATTRIBUTION_CONTROL_OFS, 32'h0, 1'b0);
    dchk(32'h10000000, 1'b0, 2'h0, 1'b0);
    dchk(32'h10000000, 1'b1, 2'h0, 1'b0);
    // Region 0 callable, region 1 Non-secure.
    wr(REGION_INDEX_SELECT_OFS, 32'h0, 1'b1);
    wr(REGION_BASE_ADDRESS_OFS, 32'h0020001f, 1'b1);
    wr(REGION_LIMIT_ADDRESS_OFS, 32'h003fffff, 1'b1);
    rd(REGION_BASE_ADDRESS_OFS, 32'h00200000, 1'b1);
    rd(REGION_LIMIT_ADDRESS_OFS, 32'h003fffe3, 1'b1);
    wr(REGION_INDEX_SELECT_OFS, 32'h1, 1'b1);
    wr(REGION_BASE_ADDRESS_OFS, 32'h20200000, 1'b1);
    wr(REGION_LIMIT_ADDRESS_OFS, 32'h203fffe1, 1'b1);
    rd(REGION_INDEX_SELECT_OFS, 32'h1, 1'b1);
    wr(REGION_INDEX_SELECT_OFS, NREG, 1'b1);
    wr(REGION_BASE_ADDRESS_OFS, 32'h12345660, 1'b1);
    rd(REGION_BASE_ADDRESS_OFS, 32'h0, 1'b1);
    rd(32'he000ede4, 32'h0, 1'b1);
    wr(ATTRIBUTION_CONTROL_OFS, 32'h1, 1'b1);
    dchk(32'h20200010, 1'b0, 2'h0, 1'b0);
    chk("testRegion", 32'h1, testRegion_q);
    chk("testRegionValid", 32'h1, testRegionValid_q);
    dchk(32'h203fffff, 1'b0, 2'h0, 1'b0);
    dchk(32'h20400000, 1'b0, 2'h2, 1'b1);
    dchk(32'h00300000, 1'b0, 2'h1, 1'b1);
    dchk(32'h00300000, 1'b1, 2'h1, 1'b0);
    echk(1'b0);
    fchk(32'h00200000, 1'b1, 2'h1, 1'b1, 1'b1, 1'b0);
    fchk(32'h10000000, 1'b1, 2'h2, 1'b0, 1'b0, 1'b1);
    fchk(32'h20200010, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0);
    // External map present.
    @(posedge clock);
    extPresent <= 1'b1;
    extAttr <= 2'h2;
    dchk(32'h20200010, 1'b0, 2'h2, 1'b1);
    @(posedge clock);
    extAttr <= 2'h0;
    dchk(32'h00300000, 1'b1, 2'h1, 1'b0);
    // Region 2 overlaps region 1.
    wr(REGION_INDEX_SELECT_OFS, 32'h2, 1'b1);
    wr(REGION_BASE_ADDRESS_OFS, 32'h20200000, 1'b1);
    wr(REGION_LIMIT_ADDRESS_OFS, 32'h202fffe1, 1'b1);
    dchk(32'h20200010, 1'b0, 2'h2, 1'b1);
    chk("testRegionValid", 32'h0, testRegionValid_q);
    // Reset in mid-run disables the unit again.
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(ATTRIBUTION_CONTROL_OFS, 32'h0, 1'b1);
    dchk(32'h20200010, 1'b0, 2'h2, 1'b1);
    summarize();
  end
endmodule : security_attribution_map_tb
`default_nettype wire
